// *** brs_pkg.sv ***
// Contract
// RULE1 - Brown-out detection pulses a whole-device reset.
// RULE2 - Clock source chosen from select and mode fields.
// RULE3 - Oscillator mode: clock held until start-up timer expires.
// RULE4 - PLL in use: clock held until lock flag reads one.
// RULE5 - Power-up delay runs concurrently, holding internal reset.
// RULE6 - Zero power-up delay with crystal: fail-safe monitor delay only.
// RULE7 - Brown-out reset sets status flag, bit one.
// RULE8 - Detection keeps working in Sleep and Idle.
// RULE9 - Release only after clock hold and delay complete.
// RULE10 - Status flag survives resets until software clears it.
package brs_pkg;

	// ------------------------------------------------------------
	// Register map.
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_RESET_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_CONFIG = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
	localparam int BIT_BROWNOUT_FLAG = 1;
	localparam int BIT_IRQ_BROWNOUT = 0;
	localparam int BIT_LOCK = 5;

	// ------------------------------------------------------------
	// Configuration encodings.
	// ------------------------------------------------------------
	localparam logic [2:0] OSC_INTERNAL_FAST = 3'h0;
	localparam logic [2:0] OSC_INTERNAL_FAST_PLL = 3'h1;
	localparam logic [2:0] OSC_PRIMARY = 3'h2;
	localparam logic [2:0] OSC_PRIMARY_PLL = 3'h3;
	localparam logic [1:0] POSC_EXTERNAL = 2'h0;
	localparam logic [1:0] POSC_XT = 2'h1;
	localparam logic [1:0] POSC_HS = 2'h2;
	localparam logic [1:0] POSC_DISABLED = 2'h3;

	// ------------------------------------------------------------
	// Timing.
	// ------------------------------------------------------------
	localparam int CLOCK_HZ = 40_000_000;
	localparam int RESET_PULSE_CYCLES = 4;
	localparam int STARTUP_CYCLES = 1024;
	localparam longint POWERUP_DELAY_US = 64000;
	localparam int POWERUP_CYCLES =
		int'((POWERUP_DELAY_US * CLOCK_HZ) / 1_000_000);
	localparam longint FAILSAFE_DELAY_US = 500;
	localparam int FAILSAFE_CYCLES =
		int'((FAILSAFE_DELAY_US * CLOCK_HZ) / 1_000_000);
	localparam int CNT_W = 32;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_PULSE = 2'b01,
		ST_WAIT = 2'b10
	} brs_state_t;

endpackage

// *** brs_sequencer.sv ***
// Design decisions made here: the register addresses and strobed register access.
module brs_sequencer #(
	parameter int POWERUP_CYCLES = brs_pkg::POWERUP_CYCLES,
	parameter int FAILSAFE_CYCLES = brs_pkg::FAILSAFE_CYCLES,
	parameter int STARTUP_CYCLES = brs_pkg::STARTUP_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_brownout,
	input wire logic i_osc_ready,
	input wire logic i_pll_lock,
	input wire logic i_low_power,
	input wire logic [2:0] i_osc_select_cfg,
	input wire logic [1:0] i_primary_osc_mode_cfg,
	input wire logic i_powerup_timer_en,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	output logic [31:0] o_rdata,
	output logic o_device_reset,
	output logic o_clock_hold,
	output logic o_internal_reset,
	output logic [1:0] o_clock_source,
	output logic o_irq
);

	// A brown-out seen while running starts a device reset pulse of at least
	// RESET_PULSE_CYCLES cycles, stretched while the brown-out input stays
	// high. The pulse is followed by a wait in which the clock hold and
	// the power-up delay run side by side. Internal reset stays high from
	// the pulse until both have finished, and a new brown-out during the
	// wait starts the pulse again, so a supply that dips twice never gets
	// a shortened sequence.

	// ------------------------------------------------------------
	// Elaboration checks.
	// ------------------------------------------------------------
	// Every counter below compares against one of these counts, and a
	// count below one would let a stage finish before it starts.
	initial begin
		if (POWERUP_CYCLES < 1) begin
			$error("Power-up delay must be at least one cycle.");
		end
		if (FAILSAFE_CYCLES < 1) begin
			$error("Fail-safe delay must be at least one cycle.");
		end
		if (STARTUP_CYCLES < 1) begin
			$error("Start-up timer must be at least one cycle.");
		end
		if (brs_pkg::RESET_PULSE_CYCLES < 1) begin
			$error("Reset pulse must be at least one cycle.");
		end
	end

	// Terminal values of the pulse counter and the start-up counter.
	localparam logic [31:0] PULSE_LAST =
		32'(brs_pkg::RESET_PULSE_CYCLES - 1);
	localparam logic [31:0] STARTUP_LAST = 32'(STARTUP_CYCLES);

	// ------------------------------------------------------------
	// Configuration decoding.
	// ------------------------------------------------------------
	// True when the oscillator select field routes through the PLL.
	function automatic logic selects_pll(input logic [2:0] sel);
		return sel == brs_pkg::OSC_INTERNAL_FAST_PLL ||
			sel == brs_pkg::OSC_PRIMARY_PLL;
	endfunction

	// True when the primary oscillator is both selected and enabled.
	function automatic logic selects_primary(input logic [2:0] sel,
		input logic [1:0] mode);
		return (sel == brs_pkg::OSC_PRIMARY ||
			sel == brs_pkg::OSC_PRIMARY_PLL) &&
			mode != brs_pkg::POSC_DISABLED;
	endfunction

	// True when the selected primary oscillator runs from a crystal.
	function automatic logic selects_crystal(input logic [2:0] sel,
		input logic [1:0] mode);
		return selects_primary(sel, mode) &&
			(mode == brs_pkg::POSC_XT || mode == brs_pkg::POSC_HS);
	endfunction

	// True when a counter has reached its terminal value.
	function automatic logic at_count(input logic [31:0] count,
		input logic [31:0] limit);
		return count == limit;
	endfunction

	// Packs the live status fields into the low bits of a read word.
	function automatic logic [5:0] status_bits(input logic pll_lock,
		input logic low_power, input logic [2:0] sel,
		input brs_pkg::brs_state_t st, input logic int_reset);
		return {pll_lock, low_power, sel != 3'h0, st, int_reset};
	endfunction

	// ------------------------------------------------------------
	// Sequencing state.
	// ------------------------------------------------------------
	brs_pkg::brs_state_t state;
	logic [31:0] pulse_count;
	logic [31:0] clock_count;
	logic [31:0] delay_count;
	logic clock_done;
	logic delay_done;
	logic uses_pll;
	logic uses_osc;
	logic crystal;
	logic brownout_flag;
	logic irq_status;
	logic irq_mask;
	logic brownout_event;
	logic lock_seen;
	logic [2:0] cfg_select;
	logic [1:0] cfg_mode;
	logic cfg_timer_en;

	// ------------------------------------------------------------
	// Configuration capture.
	// ------------------------------------------------------------
	// The fields are followed while running and during the pulse, and
	// frozen for the wait, so a field that moves mid-sequence cannot
	// shorten a hold or a delay that has already started.
	always_ff @(posedge i_clock) begin
		if (i_reset || state != brs_pkg::ST_WAIT) begin
			cfg_select <= i_osc_select_cfg;
			cfg_mode <= i_primary_osc_mode_cfg;
			cfg_timer_en <= i_powerup_timer_en;
		end
	end

	assign uses_pll = selects_pll(cfg_select);
	assign uses_osc = selects_primary(cfg_select, cfg_mode);
	assign crystal = selects_crystal(cfg_select, cfg_mode);
	// The comparator is watched in every power mode. The low-power input
	// gates nothing here, so Sleep and Idle still see a brown-out.
	assign brownout_event = i_brownout && state == brs_pkg::ST_RUN; // RULE8

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			state <= brs_pkg::ST_RUN;
		end else begin
			unique case (state)
				brs_pkg::ST_RUN: begin
					if (brownout_event) begin
						state <= brs_pkg::ST_PULSE; // RULE1
					end
				end
				// The pulse is stretched while the comparator stays high.
				brs_pkg::ST_PULSE: begin
					if (at_count(pulse_count, PULSE_LAST) &&
						!i_brownout) begin
						state <= brs_pkg::ST_WAIT;
					end
				end
				brs_pkg::ST_WAIT: begin
					if (i_brownout) begin
						state <= brs_pkg::ST_PULSE;
					end else if (clock_done && delay_done) begin
						state <= brs_pkg::ST_RUN; // RULE9
					end
				end
				default: begin
					state <= brs_pkg::ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset || state != brs_pkg::ST_PULSE) begin
			pulse_count <= 32'h0;
		end else if (!at_count(pulse_count, PULSE_LAST)) begin
			pulse_count <= pulse_count + 32'h1;
		end
	end

	// ------------------------------------------------------------
	// Clock hold: start-up timer and PLL lock, tracked side by side.
	// ------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_reset || state != brs_pkg::ST_WAIT) begin
			clock_count <= 32'h0;
		end else if (uses_osc && i_osc_ready &&
			!at_count(clock_count, STARTUP_LAST)) begin
			clock_count <= clock_count + 32'h1; // RULE3
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset || state != brs_pkg::ST_WAIT) begin
			lock_seen <= 1'b0;
		end else if (i_pll_lock) begin
			lock_seen <= 1'b1; // RULE4
		end
	end

	// Lock is latched so a PLL that drops lock briefly after first lock
	// does not restart the hold.
	assign clock_done =
		(!uses_osc || at_count(clock_count, STARTUP_LAST)) &&
		(!uses_pll || lock_seen); // RULE3 RULE4

	// ------------------------------------------------------------
	// Power-up or fail-safe delay, run alongside the clock hold.
	// ------------------------------------------------------------
	logic [31:0] delay_target;
	always_comb begin
		// With the power-up delay off, a crystal still needs the
		// fail-safe monitor time; any other source gets no delay.
		if (!cfg_timer_en && crystal) begin
			delay_target = 32'(FAILSAFE_CYCLES); // RULE6
		end else if (!cfg_timer_en) begin
			delay_target = 32'h0;
		end else begin
			delay_target = 32'(POWERUP_CYCLES); // RULE5
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset || state != brs_pkg::ST_WAIT) begin
			delay_count <= 32'h0;
		end else if (delay_count < delay_target) begin
			delay_count <= delay_count + 32'h1; // RULE5
		end
	end

	assign delay_done = delay_count >= delay_target;

	// ------------------------------------------------------------
	// Outputs.
	// ------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_device_reset <= 1'b0;
			o_clock_hold <= 1'b0;
			o_internal_reset <= 1'b0;
			o_clock_source <= 2'h0;
		end else begin
			o_device_reset <= state == brs_pkg::ST_PULSE; // RULE1
			o_clock_hold <= state != brs_pkg::ST_RUN && !clock_done;
			o_internal_reset <= state != brs_pkg::ST_RUN; // RULE9
			if (state == brs_pkg::ST_PULSE) begin
				o_clock_source <= {uses_osc, uses_pll}; // RULE2
			end
		end
	end

	// ------------------------------------------------------------
	// Registers. The status flag ignores i_reset so it outlives it.
	// ------------------------------------------------------------
	// A new brown-out wins over a clearing write in the same cycle, so
	// software can never lose an event it has not yet seen.
	always_ff @(posedge i_clock) begin
		if (brownout_event) begin
			brownout_flag <= 1'b1; // RULE7
		end else if (i_write && i_addr == brs_pkg::ADDR_RESET_CONTROL &&
			!i_wdata[brs_pkg::BIT_BROWNOUT_FLAG]) begin
			brownout_flag <= 1'b0; // RULE10
		end
	end

	// Interrupt status is write-one-to-clear, and set wins as above.
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			irq_status <= 1'b0;
		end else if (brownout_event) begin
			irq_status <= 1'b1;
		end else if (i_write && i_addr == brs_pkg::ADDR_IRQ_STATUS &&
			i_wdata[brs_pkg::BIT_IRQ_BROWNOUT]) begin
			irq_status <= 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			irq_mask <= 1'b0;
		end else if (i_write && i_addr == brs_pkg::ADDR_IRQ_MASK) begin
			irq_mask <= i_wdata[brs_pkg::BIT_IRQ_BROWNOUT];
		end
	end

	assign o_irq = irq_status && irq_mask;

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_rdata <= 32'h0;
		end else if (i_read) begin
			unique case (i_addr)
				brs_pkg::ADDR_RESET_CONTROL:
					o_rdata <= {30'h0, brownout_flag === 1'b1, 1'b0};
				brs_pkg::ADDR_CONFIG:
					o_rdata <= {26'h0, status_bits(i_pll_lock,
						i_low_power, i_osc_select_cfg, state,
						o_internal_reset)};
				brs_pkg::ADDR_IRQ_STATUS:
					o_rdata <= {31'h0, irq_status};
				brs_pkg::ADDR_IRQ_MASK:
					o_rdata <= {31'h0, irq_mask};
				default:
					o_rdata <= 32'h0;
			endcase
		end else begin
			o_rdata <= 32'h0;
		end
	end

endmodule

// *** brs_sequencer_assertions.sv ***
module brs_sequencer_checker #(
	parameter int POWERUP_CYCLES = 8,
	parameter int FAILSAFE_CYCLES = 4
) (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_brownout,
	input wire logic i_pll_lock,
	input wire logic i_low_power,
	input wire logic [2:0] i_osc_select_cfg,
	input wire logic [1:0] i_primary_osc_mode_cfg,
	input wire logic i_powerup_timer_en,
	input wire logic [3:0] i_addr,
	input wire logic i_read,
	input wire logic [31:0] o_rdata,
	input wire logic o_device_reset,
	input wire logic o_clock_hold,
	input wire logic o_internal_reset,
	input wire logic [1:0] o_clock_source
);
	int hi_cnt;
	logic xtal;
	assign xtal = i_osc_select_cfg[1] && (i_primary_osc_mode_cfg == 2'h1 ||
		i_primary_osc_mode_cfg == 2'h2);
	always_ff @(posedge i_clock) begin
		if (i_reset || !o_internal_reset) begin
			hi_cnt <= 0;
		end else begin
			hi_cnt <= hi_cnt + 1;
		end
	end
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (i_reset);
	pulse_on_brownout_a: assert property (
		!o_internal_reset && i_brownout |-> ##2 o_device_reset)
		else $error("no device reset after brownout");
	pulse_len_a: assert property (
		$rose(o_device_reset) |-> o_device_reset [*4])
		else $error("device reset pulse too short");
	reset_nest_a: assert property (o_device_reset |-> o_internal_reset)
		else $error("device reset without internal reset");
	source_cfg_a: assert property (
		o_clock_hold |-> o_clock_source == i_osc_select_cfg[1:0])
		else $error("clock source does not follow config");
	pll_hold_a: assert property (
		$fell(o_clock_hold) && o_clock_source[0] |-> $past(i_pll_lock))
		else $error("clock released before lock");
	release_after_hold_a: assert property (
		$fell(o_internal_reset) |-> !o_clock_hold)
		else $error("internal reset released during clock hold");
	powerup_len_a: assert property (
		$fell(o_internal_reset) && i_powerup_timer_en && !$past(i_reset)
		|-> hi_cnt >= POWERUP_CYCLES) else $error("power-up delay too short");
	failsafe_len_a: assert property (
		$fell(o_internal_reset) && !i_powerup_timer_en && xtal &&
		!$past(i_reset) |-> hi_cnt >= FAILSAFE_CYCLES)
		else $error("fail-safe delay too short");
	flag_set_a: assert property (
		o_device_reset && i_read && i_addr == 4'h0 |=> o_rdata[1])
		else $error("brownout flag not set");
	cover property ($fell(o_internal_reset) && !i_powerup_timer_en && xtal);
	cover property ($rose(o_device_reset) && i_low_power);
	cover property ($fell(o_clock_hold) && o_clock_source[0]);
endmodule

// *** brs_sequencer_tb_top.sv ***
module brs_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 1'h0;
	logic i_reset, i_brownout, i_osc_ready, i_pll_lock, i_low_power;
	logic i_write, i_read, i_powerup_timer_en, o_device_reset, o_clock_hold;
	logic o_internal_reset, o_irq;
	logic [2:0] i_osc_select_cfg;
	logic [1:0] i_primary_osc_mode_cfg, o_clock_source;
	logic [3:0] i_addr;
	logic [31:0] i_wdata, o_rdata, d;
	int num_errors = 0;
	int n_checks = 0;
	always #12.5 i_clock = ~i_clock;
	brs_sequencer #(.POWERUP_CYCLES(8), .FAILSAFE_CYCLES(4),
		.STARTUP_CYCLES(4))
		DUT (.i_clock, .i_reset, .i_brownout, .i_osc_ready, .i_pll_lock,
		.i_low_power, .i_osc_select_cfg, .i_primary_osc_mode_cfg,
		.i_powerup_timer_en, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata,
		.o_device_reset, .o_clock_hold, .o_internal_reset, .o_clock_source,
		.o_irq);
	task tally_and_finish;
		$display("Checks made %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= v;
		i_write <= 1'h1;
		@(posedge i_clock);
		i_write <= 1'h0;
		#1;
	endtask
	task rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge i_clock);
		i_addr <= a;
		i_read <= 1'h1;
		@(posedge i_clock);
		i_read <= 1'h0;
		#1 v = o_rdata;
	endtask
	// Fires one brownout, then brings up the oscillator and the lock late.
	task run(input logic [2:0] s, input logic [1:0] m, input logic e,
		input logic lp);
		int n;
		@(posedge i_clock);
		i_osc_select_cfg <= s;
		i_primary_osc_mode_cfg <= m;
		i_powerup_timer_en <= e;
		i_low_power <= lp;
		i_osc_ready <= 1'h0;
		i_pll_lock <= 1'h0;
		i_brownout <= 1'h1;
		@(posedge i_clock);
		i_brownout <= 1'h0;
		@(posedge i_clock);
		#1 chk("device_reset", 32'h1, o_device_reset);
		chk("clock_hold", {31'h0, s != 3'h0}, o_clock_hold);
		rd(4'h0, d);
		chk("brownout_flag", 32'h1, d[1]);
		n = 0;
		while (o_internal_reset !== 1'h0 && n < 300) begin
			@(posedge i_clock);
			n++;
			i_osc_ready <= (n >= 12);
			i_pll_lock <= (n >= 20);
			#1;
		end
		if (n >= 300) begin
			num_errors++;
			tally_and_finish();
		end
		if (s[0]) chk("pll_wait", 32'h1, n > 20);
		if (s[1]) chk("osc_wait", 32'h1, n > 14);
		chk("device_reset_end", 32'h0, o_device_reset);
		chk("clock_hold_end", 32'h0, o_clock_hold);
		chk("clock_source", {30'h0, s[1:0]}, o_clock_source);
	endtask
	initial begin
		{i_reset, i_brownout, i_osc_ready, i_pll_lock, i_low_power} = 5'h10;
		{i_write, i_read, i_powerup_timer_en} = 3'h1;
		{i_osc_select_cfg, i_primary_osc_mode_cfg, i_addr} = 9'h0;
		i_wdata = 32'h0;
		repeat (3) @(posedge i_clock);
		i_reset <= 1'h0;
		wr(4'h0, 32'h0);
		rd(4'h0, d);
		chk("flag_cleared", 32'h0, d[1]);
		rd(4'h2, d);
		chk("unmapped", 32'h0, d);
		wr(4'hc, 32'h1);
		run(3'h0, 2'h1, 1'h1, 1'h0);
		run(3'h1, 2'h1, 1'h1, 1'h1);
		run(3'h2, 2'h1, 1'h1, 1'h0);
		run(3'h3, 2'h2, 1'h1, 1'h1);
		run(3'h2, 2'h1, 1'h0, 1'h0);
		run(3'h2, 2'h2, 1'h0, 1'h1);
		run(3'h2, 2'h0, 1'h0, 1'h0);
		chk("irq_set", 32'h1, o_irq);
		wr(4'h8, 32'h1);
		chk("irq_clear", 32'h0, o_irq);
		wr(4'hc, 32'h0);
		run(3'h0, 2'h1, 1'h1, 1'h0);
		chk("irq_masked", 32'h0, o_irq);
		@(posedge i_clock);
		i_reset <= 1'h1;
		@(posedge i_clock);
		i_reset <= 1'h0;
		rd(4'h0, d);
		chk("flag_kept", 32'h1, d[1]);
		chk("internal_reset_idle", 32'h0, o_internal_reset);
		tally_and_finish();
	end
endmodule
bind brs_sequencer brs_sequencer_checker #(.POWERUP_CYCLES(POWERUP_CYCLES),
	.FAILSAFE_CYCLES(FAILSAFE_CYCLES)) chk_i (.i_clock, .i_reset, .i_brownout,
	.i_pll_lock, .i_low_power, .i_osc_select_cfg, .i_primary_osc_mode_cfg,
	.i_powerup_timer_en, .i_addr, .i_read, .o_rdata, .o_device_reset,
	.o_clock_hold, .o_internal_reset, .o_clock_source);
